// ===== rtl/servo_loop_defs.vh
// Notes on behaviour
// - all gains and settings reset to zero
// - accumulate following error while integral applied and within limit; cleared while integral applied and integral gain is zero
// - clamp integral to limit percent of full scale
// - never mode: integral term not applied
// - always mode: integral applied every sample
// - smart mode: speed zero or unchanged
// - steady mode: speed exactly zero
// - one update per selectable sample period
// - proportional term is error times gain
// - derivative term from error change times gain
// - feedforward adds demanded velocity times gain
`ifndef SERVO_LOOP_DEFS_VH
`define SERVO_LOOP_DEFS_VH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define REG_PROP_GAIN 8'h00
`define REG_INT_GAIN 8'h04
`define REG_INT_LIMIT 8'h08
`define REG_INT_MODE 8'h0c
`define REG_DERIV_GAIN 8'h10
`define REG_VFF_GAIN 8'h14
`define REG_PERIOD_SEL 8'h18
`define REG_DEMAND_POS 8'h1c
`define REG_MEASURED_POS 8'h20
`define REG_DEMAND_VEL 8'h24
`define REG_DEMAND_OUT 8'h28
`define REG_FOLLOW_ERR 8'h2c
`define REG_INT_ACC 8'h30
`define REG_SAMPLE_CNT 8'h34

// ****************************************************************
// integral modes
// ****************************************************************
`define MODE_NEVER 2'h0
`define MODE_ALWAYS 2'h1
`define MODE_SMART 2'h2
`define MODE_STEADY 2'h3

// ****************************************************************
// sample period select and timing
// ****************************************************************
`define PER_1MS 3'h0
`define PER_2MS 3'h1
`define PER_500US 3'h2
`define PER_200US 3'h3
`define PER_100US 3'h4
`define CLK_PERIOD_NS 10
`define T_1MS_NS 1000000
`define T_2MS_NS 2000000
`define T_500US_NS 500000
`define T_200US_NS 200000
`define T_100US_NS 100000

// gains are signed 32-bit with 8 fraction bits, limit in whole percent
`define GAIN_FRAC 8
`define PERCENT_FULL 100
`define HTRANS_NONSEQ_BIT 1

`endif

// ===== rtl/servo_sample_timer.v
`include "servo_loop_defs.vh"
`default_nettype none

module servo_sample_timer #(
    parameter T_1MS = `T_1MS_NS / `CLK_PERIOD_NS,
    parameter T_2MS = `T_2MS_NS / `CLK_PERIOD_NS,
    parameter T_500US = `T_500US_NS / `CLK_PERIOD_NS,
    parameter T_200US = `T_200US_NS / `CLK_PERIOD_NS,
    parameter T_100US = `T_100US_NS / `CLK_PERIOD_NS
) (
    input wire hclk,
    input wire hresetn,
    input wire [2:0] period_sel,
    output reg tick
);
    reg [31:0] cnt_r;
    reg [31:0] limit;

    // ****************************************************************
    // period decode
    // ****************************************************************
    always @*
    begin
        case (period_sel)
            `PER_2MS: limit = T_2MS;
            `PER_500US: limit = T_500US;
            `PER_200US: limit = T_200US;
            `PER_100US: limit = T_100US;
            default: limit = T_1MS;
        endcase
    end

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cnt_r <= 32'h0000_0000;
            tick <= 1'b0;
        end
        else if (cnt_r + 32'h0000_0001 >= limit)
        begin
            cnt_r <= 32'h0000_0000;
            tick <= 1'b1;
        end
        else
        begin
            cnt_r <= cnt_r + 32'h0000_0001;
            tick <= 1'b0;
        end
    end
endmodule // servo_sample_timer

`default_nettype wire

// ===== rtl/servo_loop_integral_control.v
// Chosen here: the register offsets and the AHB-Lite interface to the registers.
`include "servo_loop_defs.vh"
`default_nettype none

module servo_loop_integral_control #(
    parameter T_1MS = `T_1MS_NS / `CLK_PERIOD_NS,
    parameter T_2MS = `T_2MS_NS / `CLK_PERIOD_NS,
    parameter T_500US = `T_500US_NS / `CLK_PERIOD_NS,
    parameter T_200US = `T_200US_NS / `CLK_PERIOD_NS,
    parameter T_100US = `T_100US_NS / `CLK_PERIOD_NS,
    parameter DAC_W = 12
) (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire [31:0] hrdata,
    output wire hreadyout,
    output wire hresp,
    output reg [DAC_W-1:0] demand_out,
    output wire sample_tick
);
    // converter full scale, two's complement code
    localparam signed [47:0] FS_POS = (48'sd1 <<< (DAC_W - 1)) - 48'sd1;
    localparam signed [47:0] FS_NEG = -(48'sd1 <<< (DAC_W - 1));

    // ****************************************************************
    // software settings
    // ****************************************************************
    reg signed [31:0] prop_gain_r;
    reg signed [31:0] int_gain_r;
    reg [7:0] int_limit_r;
    reg [1:0] int_mode_r;
    reg signed [31:0] deriv_gain_r;
    reg signed [31:0] vff_gain_r;
    reg [2:0] period_sel_r;
    reg signed [31:0] dem_pos_r;
    reg signed [31:0] meas_pos_r;
    reg signed [31:0] dem_vel_r;

    // ****************************************************************
    // loop state
    // ****************************************************************
    reg signed [31:0] err_r;
    reg signed [31:0] prev_err_r;
    reg signed [31:0] prev_vel_r;
    reg signed [31:0] acc_r;
    reg [31:0] sample_cnt_r;
    reg signed [47:0] out_full_r;

    // ahb address phase capture
    reg wr_pend_r;
    reg [7:0] wr_addr_r;
    reg [31:0] rdata_r;
    reg [31:0] rdata_nxt;

    wire tick;

    servo_sample_timer #(
        .T_1MS(T_1MS),
        .T_2MS(T_2MS),
        .T_500US(T_500US),
        .T_200US(T_200US),
        .T_100US(T_100US)
    ) u_timer (
        .hclk(hclk),
        .hresetn(hresetn),
        .period_sel(period_sel_r),
        .tick(tick)
    );

    assign sample_tick = tick;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdata_r;

    wire access = hsel & hready & htrans[`HTRANS_NONSEQ_BIT];
    wire rd_access = access & !hwrite;
    wire [7:0] a_off = haddr[7:0];

    // ****************************************************************
    // loop arithmetic
    // ****************************************************************
    wire signed [31:0] err_now = dem_pos_r - meas_pos_r;
    reg apply_int;
    always @*
    begin
        case (int_mode_r)
            `MODE_NEVER: apply_int = 1'b0;
            `MODE_ALWAYS: apply_int = 1'b1;
            `MODE_SMART: apply_int = (dem_vel_r == 32'sd0) ||
                (dem_vel_r == prev_vel_r);
            `MODE_STEADY: apply_int = (dem_vel_r == 32'sd0);
            default: apply_int = 1'b0;
        endcase
    end

    // ****************************************************************
    // integral path
    // ****************************************************************
    // integral limit in output counts, from percent of full scale
    wire signed [47:0] int_lim =
        (FS_POS * $signed({40'h00_0000_0000, int_limit_r})) / `PERCENT_FULL;
    wire signed [47:0] acc_nxt = acc_r + err_now;
    wire signed [63:0] int_raw = (acc_nxt * int_gain_r) >>> `GAIN_FRAC;
    reg signed [47:0] int_term;
    always @*
    begin
        if (int_raw > int_lim)
            int_term = int_lim;
        else if (int_raw < -int_lim)
            int_term = -int_lim;
        else
            int_term = int_raw[47:0];
    end

    // integral only reaches the output when the mode allows it
    wire signed [63:0] i_term =
        apply_int ? $signed({{16{int_term[47]}}, int_term}) : 64'sd0;

    // ****************************************************************
    // demand terms
    // ****************************************************************
    wire signed [63:0] p_term = (err_now * prop_gain_r) >>> `GAIN_FRAC;
    wire signed [32:0] d_err = err_now - prev_err_r;
    wire signed [63:0] d_term = (d_err * deriv_gain_r) >>> `GAIN_FRAC;
    wire signed [63:0] v_term = (dem_vel_r * vff_gain_r) >>> `GAIN_FRAC;
    wire signed [63:0] sum_all = p_term + d_term + v_term + i_term;

    // ****************************************************************
    // saturation at converter full scale
    // ****************************************************************
    // clipping, not wrapping, so a large error never reverses the drive
    reg signed [47:0] sat_out;
    always @*
    begin
        if (sum_all > FS_POS)
            sat_out = FS_POS;
        else if (sum_all < FS_NEG)
            sat_out = FS_NEG;
        else
            sat_out = sum_all[47:0];
    end

    // ****************************************************************
    // integral accumulator
    // ****************************************************************
    // accumulator held within reach of limit, avoids windup
    wire int_in_range = (int_raw <= int_lim) && (int_raw >= -int_lim);
    reg signed [47:0] acc_hold;
    always @*
    begin
        if (int_gain_r == 32'sd0)
            acc_hold = 48'sd0;
        else
            acc_hold = acc_nxt;
    end

    // ****************************************************************
    // sample update
    // ****************************************************************
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            err_r <= 32'sd0;
            prev_err_r <= 32'sd0;
            prev_vel_r <= 32'sd0;
            acc_r <= 32'sd0;
            sample_cnt_r <= 32'h0000_0000;
            out_full_r <= 48'sd0;
            demand_out <= {DAC_W{1'b0}};
        end
        else if (tick)
        begin
            err_r <= err_now;
            prev_err_r <= err_now;
            // previous speed feeds the smart mode test of the next sample
            prev_vel_r <= dem_vel_r;
            if (apply_int && int_in_range)
                acc_r <= acc_hold[31:0];
            sample_cnt_r <= sample_cnt_r + 32'h0000_0001;
            out_full_r <= sat_out;
            demand_out <= sat_out[DAC_W-1:0];
        end
    end

    // ****************************************************************
    // ahb-lite slave, zero wait states
    // ****************************************************************
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            rdata_r <= 32'h0000_0000;
        end
        else
        begin
            wr_pend_r <= access & hwrite;
            wr_addr_r <= a_off;
            if (rd_access)
                rdata_r <= rdata_nxt;
        end
    end

    // ****************************************************************
    // readback mux
    // ****************************************************************
    // unmapped offsets read as zero so software can probe safely
    always @*
    begin
        case (a_off)
            `REG_PROP_GAIN: rdata_nxt = prop_gain_r;
            `REG_INT_GAIN: rdata_nxt = int_gain_r;
            `REG_INT_LIMIT: rdata_nxt = {24'h00_0000, int_limit_r};
            `REG_INT_MODE: rdata_nxt = {30'h0000_0000, int_mode_r};
            `REG_DERIV_GAIN: rdata_nxt = deriv_gain_r;
            `REG_VFF_GAIN: rdata_nxt = vff_gain_r;
            `REG_PERIOD_SEL: rdata_nxt = {29'h0000_0000, period_sel_r};
            `REG_DEMAND_POS: rdata_nxt = dem_pos_r;
            `REG_MEASURED_POS: rdata_nxt = meas_pos_r;
            `REG_DEMAND_VEL: rdata_nxt = dem_vel_r;
            `REG_DEMAND_OUT: rdata_nxt = out_full_r[31:0];
            `REG_FOLLOW_ERR: rdata_nxt = err_r;
            `REG_INT_ACC: rdata_nxt = acc_r;
            `REG_SAMPLE_CNT: rdata_nxt = sample_cnt_r;
            default: rdata_nxt = 32'h0000_0000;
        endcase
    end

    // ****************************************************************
    // write strobes, one per setting
    // ****************************************************************
    // writes land at the end of the data phase, when hwdata stands
    wire wr_prop = wr_pend_r && (wr_addr_r == `REG_PROP_GAIN);
    wire wr_igain = wr_pend_r && (wr_addr_r == `REG_INT_GAIN);
    wire wr_limit = wr_pend_r && (wr_addr_r == `REG_INT_LIMIT);
    wire wr_mode = wr_pend_r && (wr_addr_r == `REG_INT_MODE);
    wire wr_dgain = wr_pend_r && (wr_addr_r == `REG_DERIV_GAIN);
    wire wr_vff = wr_pend_r && (wr_addr_r == `REG_VFF_GAIN);
    wire wr_period = wr_pend_r && (wr_addr_r == `REG_PERIOD_SEL);
    wire wr_dpos = wr_pend_r && (wr_addr_r == `REG_DEMAND_POS);
    wire wr_mpos = wr_pend_r && (wr_addr_r == `REG_MEASURED_POS);
    wire wr_dvel = wr_pend_r && (wr_addr_r == `REG_DEMAND_VEL);

    // a limit above full scale means nothing, so it is held at 100 percent
    reg [7:0] limit_nxt;
    always @*
    begin
        if (hwdata[7:0] > 8'd`PERCENT_FULL)
            limit_nxt = 8'd`PERCENT_FULL;
        else
            limit_nxt = hwdata[7:0];
    end

    // ****************************************************************
    // setting registers
    // ****************************************************************
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            prop_gain_r <= 32'sd0;
            int_gain_r <= 32'sd0;
            int_limit_r <= 8'h00;
            int_mode_r <= `MODE_NEVER;
            deriv_gain_r <= 32'sd0;
            vff_gain_r <= 32'sd0;
            period_sel_r <= `PER_1MS;
            dem_pos_r <= 32'sd0;
            meas_pos_r <= 32'sd0;
            dem_vel_r <= 32'sd0;
        end
        else
        begin
            if (wr_prop)
                prop_gain_r <= hwdata;
            if (wr_igain)
                int_gain_r <= hwdata;
            if (wr_limit)
                int_limit_r <= limit_nxt;
            if (wr_mode)
                int_mode_r <= hwdata[1:0];
            if (wr_dgain)
                deriv_gain_r <= hwdata;
            if (wr_vff)
                vff_gain_r <= hwdata;
            if (wr_period)
                period_sel_r <= hwdata[2:0];
            if (wr_dpos)
                dem_pos_r <= hwdata;
            if (wr_mpos)
                meas_pos_r <= hwdata;
            if (wr_dvel)
                dem_vel_r <= hwdata;
        end
    end
endmodule // servo_loop_integral_control

`default_nettype wire

// ===== dv/servo_chk.sv
`default_nettype none
module servo_chk #(
    parameter T_1MS = 40,
    parameter T_2MS = 80,
    parameter T_500US = 20,
    parameter T_200US = 8,
    parameter T_100US = 4,
    parameter DAC_W = 12
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [DAC_W-1:0] demand_out,
    input wire logic sample_tick
);
timeunit 1ns;
timeprecision 1ps;
// ****
// bus snooping
// ****
logic wr_seen_r, rd_ap_r, unm_r, per_wr_r;
logic [2:0] per_r;
logic [1:0] skip_r;
logic [7:0] cnt_r;
int lim;
wire logic ap = hsel && hready && htrans[1];
always_comb
begin
    case (per_r)
        3'h1: lim = T_2MS;
        3'h2: lim = T_500US;
        3'h3: lim = T_200US;
        3'h4: lim = T_100US;
        default: lim = T_1MS;
    endcase
end
// first tick after a reset or period change may be short
always_ff @(posedge hclk or negedge hresetn)
begin
    if (!hresetn)
    begin
        wr_seen_r <= 1'b0;
        rd_ap_r <= 1'b0;
        unm_r <= 1'b0;
        per_wr_r <= 1'b0;
        per_r <= 3'h0;
        skip_r <= 2'h2;
        cnt_r <= 8'h00;
    end
    else
    begin
        wr_seen_r <= wr_seen_r || (ap && hwrite);
        rd_ap_r <= ap && !hwrite;
        unm_r <= ap && !hwrite && haddr[7:0] > 8'h37;
        per_wr_r <= ap && hwrite && haddr[7:0] == 8'h18;
        if (per_wr_r)
            per_r <= hwdata[2:0];
        if (per_wr_r)
            skip_r <= 2'h2;
        else if (sample_tick && skip_r != 2'h0)
            skip_r <= skip_r - 2'h1;
        cnt_r <= sample_tick ? 8'h01 : (cnt_r == 8'hff) ? cnt_r : cnt_r + 8'h01;
    end
end
// ****
// properties
// ****
out_reset_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !wr_seen_r |-> demand_out == '0) else $error("demand nonzero before any write");
regs_reset_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !wr_seen_r && rd_ap_r |-> hrdata == 32'h0) else $error("register nonzero after reset");
tick_pulse_a: assert property (@(posedge hclk) disable iff (!hresetn)
    sample_tick |=> !sample_tick) else $error("sample tick longer than one cycle");
tick_period_a: assert property (@(posedge hclk) disable iff (!hresetn)
    sample_tick && skip_r == 2'h0 |-> cnt_r == lim) else $error("wrong sample spacing");
out_on_tick_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $changed(demand_out) |-> sample_tick || $past(sample_tick))
    else $error("demand changed off a sample");
zero_wait_a: assert property (@(posedge hclk) disable iff (!hresetn)
    hreadyout) else $error("wait state inserted");
resp_okay_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !hresp) else $error("error response given");
rdata_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !rd_ap_r |-> $stable(hrdata)) else $error("read data moved without a read");
unmapped_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
    unm_r |-> hrdata == 32'h0) else $error("unmapped read not zero");
endmodule  // servo_chk
bind servo_loop_integral_control servo_chk #(.T_1MS(T_1MS), .T_2MS(T_2MS),
    .T_500US(T_500US), .T_200US(T_200US), .T_100US(T_100US), .DAC_W(DAC_W)) chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .demand_out(demand_out),
    .sample_tick(sample_tick));
`default_nettype wire

// ===== dv/amp_model.sv
`default_nettype none
module amp_model (
    input wire logic hclk,
    input wire logic signed [11:0] code,
    output var logic signed [15:0] drive_mv
);
timeunit 1ns;
timeprecision 1ps;
// full code swing maps to +/-10 V, one cycle of settling
always_ff @(posedge hclk)
    drive_mv <= 16'(int'(code) * 10000 / 2048);
endmodule  // amp_model
`default_nettype wire

// ===== dv/tb_top.sv
`default_nettype none
module tb_top;
timeunit 1ns;
timeprecision 1ps;
logic hclk = 0, hresetn = 0, hwrite = 0, hsel = 0, hreadyout, hresp, sample_tick;
logic [2:0] hsize = 0;
logic [1:0] htrans = 0;
logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
logic signed [11:0] demand_out;
logic signed [15:0] drive_mv;
logic [15:0] rnd = 16'hc6e1;
int fails = 0, checks = 0, n;
logic [1:0] md [7] = '{0, 1, 2, 2, 2, 3, 3};
logic [15:0] vl [7] = '{7, 7, 7, 0, 7, 7, 0};
logic ch [7] = '{0, 0, 0, 0, 1, 0, 0};
logic ap [7] = '{0, 1, 1, 1, 0, 0, 1};
int per [5] = '{40, 80, 20, 8, 4};
always #5 hclk = ~hclk;
servo_loop_integral_control #(.T_1MS(40), .T_2MS(80), .T_500US(20), .T_200US(8),
    .T_100US(4)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .demand_out(demand_out), .sample_tick(sample_tick));
amp_model amp (.hclk(hclk), .code(demand_out), .drive_mv(drive_mv));
// ****
// helpers
// ****
function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
endfunction
task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
        fails++;
        $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
endtask
task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    hsel <= 1'b1;
    hsize <= 3'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
endtask
// waits past n samples, with margin for the output register
task automatic tk(input int k);
    repeat (k)
    begin
        @(posedge hclk);
        for (int i = 0; i < 200 && sample_tick !== 1'b1; i++) @(posedge hclk);
    end
    repeat (2) @(posedge hclk);
endtask
task automatic rst;
    hresetn <= 0;
    repeat (6) @(posedge hclk);
    hresetn <= 1;
    @(posedge hclk);
endtask
// fresh reset so the accumulator and previous error start from zero
task automatic cfg(input logic [31:0] p, i, l, m, d, f, e, v);
    rst;
    bus(1, 8'h18, 3);
    bus(1, 8'h00, p);
    bus(1, 8'h04, i);
    bus(1, 8'h08, l);
    bus(1, 8'h0c, m);
    bus(1, 8'h10, d);
    bus(1, 8'h14, f);
    bus(1, 8'h24, v);
    bus(1, 8'h1c, e);
endtask
task automatic wrap_up;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
        $display("Testbench passed");
    else
        $display("Testbench failed");
    $finish;
endtask
initial
begin
    #300us;
    fails++;
    wrap_up;
end
// ****
// scenarios
// ****
initial
begin
    rst;
    chk("demand", demand_out, 0);
    for (int a = 0; a < 8'h40; a += 4)
    begin
        bus(0, a[7:0], 0);
        chk("reset reg", rd, 0);
    end
    for (int a = 0; a < 8'h18; a += 4)
    begin
        rnd = lfsr(rnd);
        bus(1, a[7:0], {16'h0, rnd});
        bus(0, a[7:0], 0);
        chk("readback", rd,
            a == 8 ? (rnd[7:0] > 100 ? 100 : rnd[7:0]) : a == 12 ? rnd[1:0] : rnd);
    end
    for (int s = 0; s < 5; s++)
    begin
        bus(1, 8'h18, s);
        tk(2);
        n = 0;
        do
        begin
            @(posedge hclk);
            n++;
        end while (sample_tick !== 1'b1 && n < 200);
        chk("period", n + 2, per[s]);
    end
    for (int k = 0; k < 4; k++)
    begin
        rnd = lfsr(rnd);
        cfg(32'h200, 0, 0, 0, 0, 0, rnd[7:0], 0);
        bus(1, 8'h20, rnd[15:8]);
        tk(2);
        chk("prop", demand_out, 2 * (int'(rnd[7:0]) - int'(rnd[15:8])));
        bus(0, 8'h2c, 0);
        chk("error", rd, int'(rnd[7:0]) - int'(rnd[15:8]));
    end
    cfg(32'h7f00, 0, 0, 0, 0, 0, 1000, 0);
    tk(2);
    chk("sat high", demand_out, 2047);
    chk("amp high", drive_mv, 9995);
    cfg(32'h7f00, 0, 0, 0, 0, 0, 32'hffff_fc18, 0);
    tk(2);
    chk("sat low", demand_out, 32'hffff_f800);
    chk("amp low", drive_mv, 32'hffff_d8f0);
    rnd = lfsr(rnd);
    cfg(0, 0, 0, 0, 0, 32'h300, 0, rnd[7:0]);
    tk(2);
    chk("feedforward", demand_out, 3 * rnd[7:0]);
    cfg(0, 0, 0, 0, 32'h100, 0, 60, 0);
    tk(1);
    chk("deriv step", demand_out, 60);
    tk(1);
    chk("deriv flat", demand_out, 0);
    for (int r = 0; r < 7; r++)
    begin
        cfg(0, 32'h100, 5, md[r], 0, 0, 50, vl[r]);
        for (int t = 0; t < 10; t++)
        begin
            tk(1);
            rnd = lfsr(rnd);
            if (ch[r])
                bus(1, 8'h24, rnd);
        end
        chk("integral", demand_out, ap[r] ? 5 * 2047 / 100 : 0);
    end
    wrap_up;
end
endmodule  // tb_top
`default_nettype wire
